/* File: dv/tws_watchdog_chk.sv */
module tws_watchdog_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [2:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic t0_irq_out,
    input wire logic t0_out_tick_out,
    input wire logic wd_error_out,
    input wire logic wd_active_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cfg_reg;
    // shadow of config so keyed mode and locks can be judged at the pins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg_reg <= tws_pkg::CFG_RESET;
        end else if (wr_in && addr_in == tws_pkg::ADDR_CONFIG
            && !cfg_reg[tws_pkg::CFG_LOCK_CFG]) begin
            cfg_reg <= wdata_in[5:0];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // a locked reload register swallows the write, so it starts nothing
    sequence reload_wr_s;
        wr_in && addr_in == tws_pkg::ADDR_WD_RELOAD
            && !cfg_reg[tws_pkg::CFG_LOCK_WD_RELOAD];
    endsequence
    sequence bad_key_s;
        wr_in && addr_in == tws_pkg::ADDR_WD_KEY && cfg_reg[tws_pkg::CFG_KEYED_EN]
            && wdata_in[7:0] != tws_pkg::WD_SERVICE_KEY;
    endsequence
    sequence key_wr_s;
        wr_in && addr_in == tws_pkg::ADDR_WD_KEY && cfg_reg[tws_pkg::CFG_KEYED_EN];
    endsequence
    sequence key_off_s;
        wr_in && addr_in == tws_pkg::ADDR_WD_KEY && !cfg_reg[tws_pkg::CFG_KEYED_EN]
            && !wd_active_out && !wd_error_out;
    endsequence
    active_start_a: assert property (reload_wr_s |=> wd_active_out)
        else $error("watchdog not started by reload write");
    active_idle_a: assert property (!wd_active_out && !(wr_in
        && addr_in == tws_pkg::ADDR_WD_RELOAD) |=> !wd_active_out)
        else $error("watchdog started without reload write");
    active_hold_a: assert property (wd_active_out |=> wd_active_out)
        else $error("watchdog stopped running");
    error_hold_a: assert property (wd_error_out |=> wd_error_out)
        else $error("watchdog error dropped");
    bad_key_a: assert property (bad_key_s |-> ##[1:3] wd_error_out)
        else $error("wrong key gave no error");
    double_key_a: assert property (key_wr_s ##1 key_wr_s |=> wd_error_out)
        else $error("second key write in one tick gave no error");
    key_off_a: assert property (key_off_s |=> !wd_error_out)
        else $error("key write with keyed service off gave an error");
    irq_tick_a: assert property (t0_irq_out |-> t0_out_tick_out)
        else $error("interrupt without underflow");
    tick_pulse_a: assert property (t0_out_tick_out |=> !t0_out_tick_out)
        else $error("underflow tick longer than one cycle");
    wo_read_a: assert property (rd_in && (addr_in == tws_pkg::ADDR_WD_RELOAD
        || addr_in == tws_pkg::ADDR_WD_KEY) |=> rdata_out == 16'h0000)
        else $error("write-only register read back data");
endmodule

bind tws_watchdog tws_watchdog_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .t0_irq_out(t0_irq_out), .t0_out_tick_out(t0_out_tick_out),
    .wd_error_out(wd_error_out), .wd_active_out(wd_active_out));

/* File: dv/tws_watchdog_test.sv */
module tws_watchdog_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic slow_clk_in = 1'b0;
    logic freeze_in = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [15:0] rdata_out;
    logic t0_irq_out, t0_out_tick_out, wd_error_out, wd_active_out;
    logic [2:0] slow_cnt = 3'h0;
    logic [15:0] rv;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;

    tws_watchdog u_dut (.clk_in(clk_in), .rst_in(rst_in), .slow_clk_in(slow_clk_in),
        .freeze_in(freeze_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .t0_irq_out(t0_irq_out),
        .t0_out_tick_out(t0_out_tick_out), .wd_error_out(wd_error_out),
        .wd_active_out(wd_active_out));

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    // slow clock at clk/8, inside the synchroniser limit of clk/4
    always @(posedge clk_in) begin
        slow_cnt <= slow_cnt + 3'h1;
        slow_clk_in <= slow_cnt[2];
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rst();
        rst_in <= 1'b1;
        freeze_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(posedge clk_in);
        d = rdata_out;
    endtask
    task automatic wait_tick(input int lim, output int c);
        c = 0;
        do begin
            @(posedge clk_in);
            c++;
        end while (t0_out_tick_out !== 1'b1 && c < lim);
    endtask
    task automatic t_regs();
        rst();
        rd(tws_pkg::ADDR_T0_CTRL, rv);
        chk(rv, 16'h0000);
        rd(tws_pkg::ADDR_WD_RELOAD, rv);
        chk(rv, 16'h0000);
        chk({15'h0000, wd_active_out}, 16'h0000);
        wr(tws_pkg::ADDR_T0_CTRL, 16'h0006);
        rd(tws_pkg::ADDR_T0_CTRL, rv);
        chk(rv, 16'h0004);
        // default timer 0 output is far off, so no watchdog tick clears the flag yet
        wr(tws_pkg::ADDR_WD_RELOAD, 16'h0040);
        rd(tws_pkg::ADDR_T0_CTRL, rv);
        chk(rv, 16'h000c);
        wr(tws_pkg::ADDR_CONFIG, 16'h0010);
        repeat (12) @(posedge clk_in);
        rd(tws_pkg::ADDR_T0_CTRL, rv);
        chk(rv, 16'h0004);
    endtask
    task automatic t_rate();
        for (int m = 0; m < 6; m++) begin
            rst();
            wr(tws_pkg::ADDR_PRESCALER, 16'(m));
            wr(tws_pkg::ADDR_T0_RELOAD, 16'(m + 1));
            wr(tws_pkg::ADDR_T0_CTRL, 16'h0001);
            wait_tick(4000, n);
            wait_tick(4000, n);
            chk(16'(n), 16'((m + 2) * (8 << m)));
        end
    endtask
    task automatic t_tc();
        rst();
        wr(tws_pkg::ADDR_T0_RELOAD, 16'h0010);
        wr(tws_pkg::ADDR_T0_CTRL, 16'h0005);
        wait_tick(4000, n);
        chk({15'h0000, t0_irq_out}, 16'h0001);
        rd(tws_pkg::ADDR_T0_CTRL, rv);
        chk(rv, 16'h0006);
        rd(tws_pkg::ADDR_T0_CTRL, rv);
        chk(rv, 16'h0004);
        freeze_in <= 1'b1;
        // first wait only aligns to a tick; the second spans one whole period
        wait_tick(400, n);
        wait_tick(400, n);
        chk(16'(n), 16'h0088);
        repeat (4) @(posedge clk_in);
        rd(tws_pkg::ADDR_T0_CTRL, rv);
        chk(rv, 16'h0006);
        freeze_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        // this read still sees the held flag and clears it
        rd(tws_pkg::ADDR_T0_CTRL, rv);
        chk(rv, 16'h0006);
        rd(tws_pkg::ADDR_T0_CTRL, rv);
        chk(rv, 16'h0004);
        wr(tws_pkg::ADDR_T0_CTRL, 16'h0014);
        freeze_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        wait_tick(400, n);
        chk(16'(n), 16'h0190);
        freeze_in <= 1'b0;
        wait_tick(400, n);
        chk({15'h0000, t0_out_tick_out}, 16'h0001);
    endtask
    task automatic t_wd();
        rst();
        wr(tws_pkg::ADDR_CONFIG, 16'h0010);
        wr(tws_pkg::ADDR_WD_RELOAD, 16'h0004);
        // the write lands at the edge wr returns on; look one edge later
        @(posedge clk_in);
        chk({15'h0000, wd_active_out}, 16'h0001);
        repeat (24) @(posedge clk_in);
        wr(tws_pkg::ADDR_WD_RELOAD, 16'h0004);
        repeat (24) @(posedge clk_in);
        chk({15'h0000, wd_error_out}, 16'h0000);
        repeat (30) @(posedge clk_in);
        chk({15'h0000, wd_error_out}, 16'h0001);
        rst();
        wr(tws_pkg::ADDR_T0_RELOAD, 16'h0001);
        wr(tws_pkg::ADDR_T0_CTRL, 16'h0001);
        wr(tws_pkg::ADDR_WD_RELOAD, 16'h0004);
        repeat (50) @(posedge clk_in);
        chk({15'h0000, wd_error_out}, 16'h0000);
        repeat (60) @(posedge clk_in);
        chk({15'h0000, wd_error_out}, 16'h0001);
        rst();
        wr(tws_pkg::ADDR_CONFIG, 16'h0010);
        freeze_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        wr(tws_pkg::ADDR_WD_RELOAD, 16'h0002);
        repeat (100) @(posedge clk_in);
        chk({15'h0000, wd_error_out}, 16'h0000);
        freeze_in <= 1'b0;
        repeat (40) @(posedge clk_in);
        chk({15'h0000, wd_error_out}, 16'h0001);
    endtask
    // watchdog ticks every 256 clocks, so one write per tick is easy to keep
    task automatic key_setup();
        rst();
        wr(tws_pkg::ADDR_PRESCALER, 16'h0005);
        wr(tws_pkg::ADDR_CONFIG, 16'h0010);
        wr(tws_pkg::ADDR_WD_RELOAD, 16'h0002);
        // locked sequence: every lock bit plus keyed service, clock select kept
        wr(tws_pkg::ADDR_CONFIG, 16'h003f);
        repeat (300) @(posedge clk_in);
    endtask
    task automatic t_key();
        key_setup();
        wr(tws_pkg::ADDR_PRESCALER, 16'h0000);
        rd(tws_pkg::ADDR_PRESCALER, rv);
        chk(rv, 16'h0005);
        wr(tws_pkg::ADDR_WD_KEY, 16'h005c);
        repeat (300) @(posedge clk_in);
        wr(tws_pkg::ADDR_WD_KEY, 16'h005c);
        repeat (300) @(posedge clk_in);
        chk({15'h0000, wd_error_out}, 16'h0000);
        wr(tws_pkg::ADDR_WD_KEY, 16'h0000);
        repeat (4) @(posedge clk_in);
        chk({15'h0000, wd_error_out}, 16'h0001);
        key_setup();
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= tws_pkg::ADDR_WD_KEY;
        wdata_in <= 16'h005c;
        repeat (2) @(posedge clk_in);
        wr_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk({15'h0000, wd_error_out}, 16'h0001);
        rst();
        wr(tws_pkg::ADDR_CONFIG, 16'h0001);
        wr(tws_pkg::ADDR_CONFIG, 16'h0020);
        wr(tws_pkg::ADDR_WD_KEY, 16'h0000);
        wr(tws_pkg::ADDR_WD_KEY, 16'h005c);
        repeat (4) @(posedge clk_in);
        chk({15'h0000, wd_error_out}, 16'h0000);
        chk({15'h0000, wd_active_out}, 16'h0000);
    endtask

    initial begin
        t_regs();
        $display("registers done");
        t_rate();
        $display("timer rate done");
        t_tc();
        $display("terminal count done");
        t_wd();
        $display("watchdog done");
        t_key();
        $display("service key done");
        close_out();
    end
endmodule

/* File: logic/tws_pkg.sv */
// What this block does and what software must do
// [R1] terminal count bit is read-only; writes to it are discarded
// [R2] terminal count survives a control read while freeze is asserted
// [R3] freeze enable set: timer 0 stops during freeze
// [R4] freeze enable clear: only watchdog stops, timer 0 runs
// [R5] timer 0 freeze enable is cleared at reset
// [R6] write-only 8-bit watchdog reload, loaded on every service
// [R7] watchdog idle after reset, starts on first reload write
// [R8] every later reload write restarts the count with the new value
// [R9] watchdog reload resets to 0Fh
// [R10] keyed mode: writing 5Ch to service key reloads from reload register
// [R11] keyed mode: any other key value raises watchdog error
// [R12] two service-key writes in one watchdog clock raise error
// [R13] keyed mode off: service-key writes ignored completely
// [R14] timer 0 output rate is input rate over preset plus one
// [R15] prescaled input is slow clock divided by 1,2,4,8,16 or 32
// [R16] watchdog clock is prescaled input or timer 0 output
// [R17] reload value sets max watchdog clocks between services
// [R18] software restarts timer 0 via restart bit after loading preset
// [R19] software sets config bits 0,1,2,3,5 for best protection
// [R20] software services once per period, never twice per watchdog clock
// [R21] select 0 uses timer 0 output, 1 uses prescaled input
// [R22] timer 0 counts down, reloads preset on underflow, preset resets FFFFh
// [R23] restart bit reloads on next input tick, cleared on that tick
// [R24] config lock bits block writes to their registers
// [R25] watchdog decrements per selected clock, errors on expiry
// [R26] terminal count set at zero, cleared by control read outside freeze
// [R27] interrupt enable gives an interrupt each time timer 0 hits zero
// [R28] last touch delay flag set while a write is still transferring
package tws_pkg;
    localparam logic [2:0] ADDR_CONFIG = 3'h0;
    localparam logic [2:0] ADDR_PRESCALER = 3'h1;
    localparam logic [2:0] ADDR_T0_RELOAD = 3'h2;
    localparam logic [2:0] ADDR_T0_CTRL = 3'h3;
    localparam logic [2:0] ADDR_WD_RELOAD = 3'h4;
    localparam logic [2:0] ADDR_WD_KEY = 3'h5;

    localparam int CFG_LOCK_CFG = 0;
    localparam int CFG_LOCK_PRESCALER = 1;
    localparam int CFG_LOCK_T0 = 2;
    localparam int CFG_LOCK_WD_RELOAD = 3;
    localparam int CFG_WD_CLK_SEL = 4;
    localparam int CFG_KEYED_EN = 5;
    localparam logic [5:0] CFG_RESET = 6'h00;

    localparam int CTL_RESTART = 0;
    localparam int CTL_TC = 1;
    localparam int CTL_IRQ_EN = 2;
    localparam int CTL_LTD = 3;
    localparam int CTL_FRZ_EN = 4;

    localparam logic [2:0] MDIV_RESET = 3'h0;
    localparam logic [2:0] MDIV_MAX = 3'h5;
    localparam logic [15:0] T0_PRESET_RESET = 16'hffff;
    localparam logic [7:0] WD_RELOAD_RESET = 8'h0f;
    localparam logic [7:0] WD_SERVICE_KEY = 8'h5c;

    // divisor 2**mdiv as a mask of prescaler bits; reserved codes act as /32
    function automatic logic [4:0] div_mask(input logic [2:0] mdiv);
        logic [2:0] m;
        m = (mdiv > MDIV_MAX) ? MDIV_MAX : mdiv;
        div_mask = 5'((6'h01 << m) - 6'h01);
    endfunction
endpackage

/* File: logic/tws_prescaler.sv */
module tws_prescaler (
    input wire logic clk_in,
    input wire logic rst_in,
    tws_tick_if.prescaler tick_if
);
    logic [4:0] div_cnt_reg;
    logic [4:0] mask;

    assign mask = tws_pkg::div_mask(tick_if.mdiv);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div_cnt_reg <= 5'h00;
        end else if (tick_if.slow_tick) begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
        end
    end

    // one tick each 2**mdiv slow clocks
    assign tick_if.prescaled_slow_clock_tick = tick_if.slow_tick && ((div_cnt_reg & mask) == mask); // [R15]
endmodule

/* File: logic/tws_tick_if.sv */
interface tws_tick_if;
    logic slow_tick;
    logic [2:0] mdiv;
    logic prescaled_slow_clock_tick;
    logic [15:0] preset;
    logic restart_req;
    logic restart_done;
    logic hold;
    logic timer_zero_output_clock_tick;

    modport prescaler (
        input slow_tick,
        input mdiv,
        output prescaled_slow_clock_tick
    );
    modport timer (
        input prescaled_slow_clock_tick,
        input preset,
        input restart_req,
        input hold,
        output restart_done,
        output timer_zero_output_clock_tick
    );
endinterface

/* File: logic/tws_timer0.sv */
module tws_timer0 (
    input wire logic clk_in,
    input wire logic rst_in,
    tws_tick_if.timer tick_if
);
    logic [15:0] count_reg;
    logic step;

    assign step = tick_if.prescaled_slow_clock_tick && !tick_if.hold; // [R3] [R4]
    assign tick_if.restart_done = step && tick_if.restart_req; // [R23]
    // underflow gives preset+1 input ticks per output tick
    assign tick_if.timer_zero_output_clock_tick = step && !tick_if.restart_req && (count_reg == 16'h0000); // [R14]

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_reg <= tws_pkg::T0_PRESET_RESET;
        end else if (step) begin
            if (tick_if.restart_req || count_reg == 16'h0000) begin
                count_reg <= tick_if.preset; // [R22] [R23]
            end else begin
                count_reg <= count_reg - 16'h0001; // [R22]
            end
        end
    end
endmodule

/* File: logic/tws_watchdog.sv */
// The plain strobed port and the register addresses are this design's own decisions.
module tws_watchdog (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic slow_clk_in,
    input wire logic freeze_in,
    input wire logic [2:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    output logic t0_irq_out,
    output logic t0_out_tick_out,
    output logic wd_error_out,
    output logic wd_active_out
);
    tws_tick_if tick_if ();

    // pin synchronisers
    logic slow_meta_reg;
    logic slow_sync_reg;
    logic slow_prev_reg;
    logic frz_meta_reg;
    logic frz_sync_reg;

    // software-visible state
    logic [5:0] config_reg;
    logic [2:0] mdiv_reg;
    logic [15:0] t0_preset_reg;
    logic restart_reg;
    logic tc_reg;
    logic irq_en_reg;
    logic frz_en_reg;
    logic [7:0] wd_reload_reg;

    // watchdog, timer 0 output and read data state
    logic wd_active_reg;
    logic [7:0] wd_count_reg;
    logic wd_error_reg;
    logic serviced_reg;
    logic ltd_reg;
    logic irq_reg;
    logic tout_reg;
    logic [15:0] rdata_reg;

    logic wr_cfg;
    logic wr_pre;
    logic wr_t0;
    logic wr_ctl;
    logic wr_wdr;
    logic wr_key;
    logic rd_ctl;
    logic keyed;
    logic key_good;
    logic service;
    logic key_error;
    logic wd_tick;
    logic wd_step;

    // slow clock must run at most a quarter of clk_in for the edge detect
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            slow_meta_reg <= 1'b0;
            slow_sync_reg <= 1'b0;
            slow_prev_reg <= 1'b0;
            frz_meta_reg <= 1'b0;
            frz_sync_reg <= 1'b0;
        end else begin
            slow_meta_reg <= slow_clk_in;
            slow_sync_reg <= slow_meta_reg;
            slow_prev_reg <= slow_sync_reg;
            frz_meta_reg <= freeze_in;
            frz_sync_reg <= frz_meta_reg;
        end
    end

    assign tick_if.slow_tick = slow_sync_reg && !slow_prev_reg;
    assign tick_if.mdiv = mdiv_reg;
    assign tick_if.preset = t0_preset_reg;
    assign tick_if.restart_req = restart_reg;
    assign tick_if.hold = frz_sync_reg && frz_en_reg; // [R3] [R4]

    tws_prescaler u_prescaler (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tick_if(tick_if)
    );

    tws_timer0 u_timer0 (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tick_if(tick_if)
    );

    // register decode with lock gating
    assign keyed = config_reg[tws_pkg::CFG_KEYED_EN];
    assign wr_cfg = wr_in && addr_in == tws_pkg::ADDR_CONFIG
        && !config_reg[tws_pkg::CFG_LOCK_CFG]; // [R24]
    assign wr_pre = wr_in && addr_in == tws_pkg::ADDR_PRESCALER
        && !config_reg[tws_pkg::CFG_LOCK_PRESCALER]; // [R24]
    assign wr_t0 = wr_in && addr_in == tws_pkg::ADDR_T0_RELOAD
        && !config_reg[tws_pkg::CFG_LOCK_T0]; // [R24]
    assign wr_ctl = wr_in && addr_in == tws_pkg::ADDR_T0_CTRL
        && !config_reg[tws_pkg::CFG_LOCK_T0]; // [R24]
    assign wr_wdr = wr_in && addr_in == tws_pkg::ADDR_WD_RELOAD
        && !config_reg[tws_pkg::CFG_LOCK_WD_RELOAD]; // [R24]
    assign wr_key = wr_in && addr_in == tws_pkg::ADDR_WD_KEY && keyed; // [R13]
    assign rd_ctl = rd_in && addr_in == tws_pkg::ADDR_T0_CTRL;

    assign key_good = wdata_in[7:0] == tws_pkg::WD_SERVICE_KEY;
    // a key write in a watchdog clock already serviced is an error too
    assign key_error = wr_key && (!key_good || serviced_reg); // [R11] [R12]
    assign service = wr_wdr || (wr_key && key_good && !serviced_reg); // [R8] [R10]

    // watchdog clock source
    assign wd_tick = config_reg[tws_pkg::CFG_WD_CLK_SEL] ? tick_if.prescaled_slow_clock_tick
        : tick_if.timer_zero_output_clock_tick; // [R16] [R21]
    assign wd_step = wd_tick && !frz_sync_reg; // [R4]

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            config_reg <= tws_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            config_reg <= wdata_in[5:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mdiv_reg <= tws_pkg::MDIV_RESET;
        end else if (wr_pre) begin
            mdiv_reg <= wdata_in[2:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            t0_preset_reg <= tws_pkg::T0_PRESET_RESET; // [R22]
        end else if (wr_t0) begin
            t0_preset_reg <= wdata_in;
        end
    end

    // control bits; terminal count is not taken from the write data
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_en_reg <= 1'b0;
            frz_en_reg <= 1'b0; // [R5]
        end else if (wr_ctl) begin
            irq_en_reg <= wdata_in[tws_pkg::CTL_IRQ_EN];
            frz_en_reg <= wdata_in[tws_pkg::CTL_FRZ_EN];
        end
    end

    // restart: write 1 sets, hardware clears on the reloading tick
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            restart_reg <= 1'b0;
        end else if (wr_ctl && wdata_in[tws_pkg::CTL_RESTART]) begin
            restart_reg <= 1'b1; // [R18] [R23]
        end else if (tick_if.restart_done) begin
            restart_reg <= 1'b0; // [R23]
        end
    end

    // terminal count: set wins over the read clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tc_reg <= 1'b0;
        end else if (tick_if.timer_zero_output_clock_tick) begin
            tc_reg <= 1'b1; // [R26]
        end else if (rd_ctl && !frz_sync_reg) begin
            tc_reg <= 1'b0; // [R1] [R2] [R26]
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_reg <= 1'b0;
            tout_reg <= 1'b0;
        end else begin
            irq_reg <= tick_if.timer_zero_output_clock_tick && irq_en_reg; // [R27]
            tout_reg <= tick_if.timer_zero_output_clock_tick; // [R14]
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wd_reload_reg <= tws_pkg::WD_RELOAD_RESET; // [R9]
        end else if (wr_wdr) begin
            wd_reload_reg <= wdata_in[7:0]; // [R6]
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wd_active_reg <= 1'b0; // [R7]
        end else if (wr_wdr) begin
            wd_active_reg <= 1'b1; // [R7]
        end
    end

    // counter takes the freshly written value on a reload write
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wd_count_reg <= tws_pkg::WD_RELOAD_RESET;
        end else if (wr_wdr) begin
            wd_count_reg <= wdata_in[7:0]; // [R6] [R8] [R17]
        end else if (service) begin
            wd_count_reg <= wd_reload_reg; // [R10]
        end else if (wd_active_reg && wd_step && wd_count_reg != 8'h00) begin
            wd_count_reg <= wd_count_reg - 8'h01; // [R25]
        end
    end

    // one service per watchdog clock; a new tick reopens the window
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            serviced_reg <= 1'b0;
        end else if (wr_key || wr_wdr) begin
            serviced_reg <= 1'b1; // [R12]
        end else if (wd_tick) begin
            serviced_reg <= 1'b0;
        end
    end

    // error holds until reset; it is meant to reset the chip
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wd_error_reg <= 1'b0;
        end else if (key_error) begin
            wd_error_reg <= 1'b1; // [R11] [R12]
        end else if (wd_active_reg && wd_step && wd_count_reg == 8'h00 && !service) begin
            wd_error_reg <= 1'b1; // [R25]
        end
    end

    // write is handed to the watchdog clock on its next tick
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ltd_reg <= 1'b0;
        end else if (wr_wdr || wr_key) begin
            ltd_reg <= 1'b1; // [R28]
        end else if (wd_tick) begin
            ltd_reg <= 1'b0; // [R28]
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_reg <= 16'h0000;
        end else if (rd_in) begin
            case (addr_in)
                tws_pkg::ADDR_CONFIG: rdata_reg <= {10'h000, config_reg};
                tws_pkg::ADDR_PRESCALER: rdata_reg <= {13'h0000, mdiv_reg};
                tws_pkg::ADDR_T0_RELOAD: rdata_reg <= t0_preset_reg;
                tws_pkg::ADDR_T0_CTRL: rdata_reg <= {11'h000, frz_en_reg, ltd_reg,
                    irq_en_reg, tc_reg, restart_reg};
                default: rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign rdata_out = rdata_reg;
    assign t0_irq_out = irq_reg;
    assign t0_out_tick_out = tout_reg;
    assign wd_error_out = wd_error_reg;
    assign wd_active_out = wd_active_reg;
endmodule
